// File: inc/pcc_pkg.sv
// Purpose: Shared constants for the clock configuration block
// Assumes: AXI4-Lite with 32-bit data, 8-bit byte address, one word per register
// Notes:   Register index times four gives the byte address
`default_nettype none

package pcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [IDX_W-1:0] IDX_PREDIV = 6'h04;
  localparam logic [IDX_W-1:0] IDX_SETUP0 = 6'h06;
  localparam logic [IDX_W-1:0] IDX_SETUP1 = 6'h08;
  localparam logic [IDX_W-1:0] IDX_SETUP2 = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_SETUP3 = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_MULT = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_DUMMY = 6'h10;
  localparam logic [IDX_W-1:0] IDX_SRC = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int LOCK_BIT = 7;
  localparam int PREDIV_W = 6;
  localparam logic [PREDIV_W-1:0] PREDIV_MAX = 6'h20;
  localparam int MULT_W = 7;
  localparam int PDIV_LSB = 3;
  localparam int PDIV_W = 5;
  localparam int SRC_BIT = 0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int IRQ_W = 2;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_SWITCH = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SETTLE_MS = 10;
  localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {SW_RUN, SW_WAIT_LOW, SW_WAIT_NEW} pcc_sw_e;

endpackage

`default_nettype wire

// File: rtl/pcc_edge_div.sv
// Purpose: Divides a stream of edge events into a toggling level
// Assumes: Ratio is at least one; a new ratio is compared on every edge, so it applies to the half period in progress
// Notes:   Equal edge counts per half period keep any ratio at 50/50
`default_nettype none

module pcc_edge_div #(
  parameter int W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic edge_in,
  input wire logic [W-1:0] ratio,
  output logic level_r,
  output logic edge_r
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      level_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      edge_r <= 1'b0;
      if (edge_in) begin
        if (cnt_r + W'(1) >= ratio) begin
          cnt_r <= '0;
          level_r <= ~level_r;
          edge_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + W'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/pcc_axil.sv
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: Core decodes addresses combinationally and returns read data the same cycle
// Notes:   One write and one read in flight; write data below lane 0 only
`default_nettype none

module pcc_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pcc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [pcc_pkg::ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_hit,
  output logic rd_en,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data
);

  logic aw_have_r;
  logic w_have_r;
  logic [pcc_pkg::ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic aw_have_nxt;
  logic w_have_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;

  // Ready flops follow the next holding state, so they match a gate on the current state
  assign aw_have_nxt = !(aw_have_r && w_have_r) && (aw_have_r || (s_axi_awvalid && s_axi_awready));
  assign w_have_nxt = !(aw_have_r && w_have_r) && (w_have_r || (s_axi_wvalid && s_axi_wready));
  assign bvalid_nxt = (aw_have_r && w_have_r) || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_nxt = rd_en || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
      s_axi_wready <= !w_have_nxt && !bvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
    end
  end
  // Lane 0 disabled turns the write into a no-op that still answers
  assign wr_en = aw_have_r && w_have_r && wlane_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign rd_en = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (aw_have_r && w_have_r) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pcc_pkg::RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {{(pcc_pkg::DATA_W-8){1'b0}}, rd_hit ? rd_data : 8'h00};
      s_axi_rresp <= rd_hit ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: rtl/pcc_top.sv
// Purpose: PLL setup registers, system clock source select and panel clock divider
// Assumes: Clocks are modelled as levels that toggle on aclk edges; the external
//          clock input is a pin much slower than aclk
// Notes:   Each toggle of a modelled clock is one edge event; the PLL is a rate model
`default_nettype none

// Contract
// - PLL output equals reference times multiplier field plus one.
// - A write to the dummy register changes no hardware state.
// - Panel clock divides system clock by code plus one; code zero reserved.
// - Panel clock keeps 50/50 duty for every ratio, odd ones too.
// - Source bit zero picks external input, one picks PLL output.
// - PLL counts as stable only after 10 ms settling after configuration.
// - Lock flag at bit 7 of pre-divider register reports PLL stability.
// - Reference is external input divided by pre-divider plus one, max 20h.
module pcc_top #(
  parameter int SETTLE_CYCLES = pcc_pkg::SETTLE_CYC,
  parameter int PER_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pcc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_clock_input,
  output logic system_clock,
  output logic panel_clock,
  output logic pll_lock,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic wr_en;
  logic [pcc_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_hit;
  logic rd_en;
  logic rd_hit;
  logic [7:0] rd_data;
  logic [pcc_pkg::IDX_W-1:0] wr_idx;
  logic [pcc_pkg::IDX_W-1:0] rd_idx;

  pcc_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_hit(wr_hit),
    .rd_en(rd_en),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  assign wr_idx = wr_addr[pcc_pkg::ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[pcc_pkg::ADDR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [pcc_pkg::PREDIV_W-1:0] prediv_r;
  logic [7:0] setup0_r;
  logic [7:0] setup1_r;
  logic [7:0] setup2_r;
  logic [7:0] setup3_r;
  logic [pcc_pkg::MULT_W-1:0] mult_r;
  logic [7:0] src_r;
  logic [pcc_pkg::IRQ_W-1:0] irq_stat_r;
  logic [pcc_pkg::IRQ_W-1:0] irq_mask_r;
  logic [pcc_pkg::IRQ_W-1:0] irq_evt;
  logic cfg_wr;

  // Setup registers are held only; software owns their fixed values
  // plain storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prediv_r <= pcc_pkg::RST_REG[pcc_pkg::PREDIV_W-1:0];
      setup0_r <= pcc_pkg::RST_REG;
      setup1_r <= pcc_pkg::RST_REG;
      setup2_r <= pcc_pkg::RST_REG;
      setup3_r <= pcc_pkg::RST_REG;
      mult_r <= pcc_pkg::RST_REG[pcc_pkg::MULT_W-1:0];
      src_r <= pcc_pkg::RST_REG;
      irq_mask_r <= pcc_pkg::RST_REG[pcc_pkg::IRQ_W-1:0];
    end else if (wr_en) begin
      case (wr_idx)
        pcc_pkg::IDX_PREDIV: prediv_r <= wr_data[pcc_pkg::PREDIV_W-1:0];
        pcc_pkg::IDX_SETUP0: setup0_r <= wr_data;
        pcc_pkg::IDX_SETUP1: setup1_r <= wr_data;
        pcc_pkg::IDX_SETUP2: setup2_r <= wr_data;
        pcc_pkg::IDX_SETUP3: setup3_r <= wr_data;
        pcc_pkg::IDX_MULT: mult_r <= wr_data[pcc_pkg::MULT_W-1:0];
        pcc_pkg::IDX_SRC: src_r <= {wr_data[7:pcc_pkg::PDIV_LSB], 2'h0, wr_data[pcc_pkg::SRC_BIT]};
        pcc_pkg::IDX_IRQ_MASK: irq_mask_r <= wr_data[pcc_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Any PLL-affecting write restarts settling; the dummy slot does not
  assign cfg_wr = wr_en && (wr_idx == pcc_pkg::IDX_PREDIV || wr_idx == pcc_pkg::IDX_SETUP0 ||
                            wr_idx == pcc_pkg::IDX_SETUP1 || wr_idx == pcc_pkg::IDX_SETUP2 ||
                            wr_idx == pcc_pkg::IDX_SETUP3 || wr_idx == pcc_pkg::IDX_MULT);

  always_comb begin
    wr_hit = 1'b1;
    case (wr_idx)
      pcc_pkg::IDX_PREDIV, pcc_pkg::IDX_SETUP0, pcc_pkg::IDX_SETUP1, pcc_pkg::IDX_SETUP2,
      pcc_pkg::IDX_SETUP3, pcc_pkg::IDX_MULT, pcc_pkg::IDX_DUMMY, pcc_pkg::IDX_SRC,
      pcc_pkg::IDX_IRQ_STAT, pcc_pkg::IDX_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 8'h00;
    case (rd_idx)
      pcc_pkg::IDX_PREDIV: rd_data = {pll_lock, 1'b0, prediv_r};
      pcc_pkg::IDX_SETUP0: rd_data = setup0_r;
      pcc_pkg::IDX_SETUP1: rd_data = setup1_r;
      pcc_pkg::IDX_SETUP2: rd_data = setup2_r;
      pcc_pkg::IDX_SETUP3: rd_data = setup3_r;
      pcc_pkg::IDX_MULT: rd_data = {1'b0, mult_r};
      pcc_pkg::IDX_DUMMY: rd_data = 8'h00;
      pcc_pkg::IDX_SRC: rd_data = src_r;
      pcc_pkg::IDX_IRQ_STAT: rd_data = {{(8-pcc_pkg::IRQ_W){1'b0}}, irq_stat_r};
      pcc_pkg::IDX_IRQ_MASK: rd_data = {{(8-pcc_pkg::IRQ_W){1'b0}}, irq_mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read clears, but an event in the same cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else if (rd_en && rd_idx == pcc_pkg::IDX_IRQ_STAT) begin
      irq_stat_r <= irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock pin
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= external_clock_input;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  assign ext_edge = ext_sync_r ^ ext_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // PLL reference and output rate model
  logic [pcc_pkg::PREDIV_W-1:0] ref_ratio;
  logic ref_level;
  logic ref_edge;
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-1:0] per_r;
  logic [PER_W-1:0] acc_r;
  logic [PER_W-1:0] acc_sum;
  logic [PER_W-1:0] mult_step;
  logic pll_edge;

  assign ref_ratio = (prediv_r > pcc_pkg::PREDIV_MAX ? pcc_pkg::PREDIV_MAX : prediv_r) +
                     pcc_pkg::PREDIV_W'(1);

  pcc_edge_div #(.W(pcc_pkg::PREDIV_W)) u_ref_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .edge_in(ext_edge),
    .ratio(ref_ratio),
    .level_r(ref_level),
    .edge_r(ref_edge)
  );

  // Reference period in aclk cycles, taken on each rising reference edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_r <= '0;
      per_r <= '0;
    end else if (ref_edge && ref_level) begin
      per_cnt_r <= PER_W'(1);
      per_r <= per_cnt_r;
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + PER_W'(1);
    end
  end

  // two edges per output period, (field + 1) periods per reference period
  assign mult_step = PER_W'({mult_r, 1'b0}) + PER_W'(2);
  assign acc_sum = acc_r + mult_step;
  assign pll_edge = (per_r != '0) && (acc_sum >= per_r);

  // Output edge rate saturates at one per aclk cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= '0;
    end else if (per_r == '0) begin
      acc_r <= '0;
    end else if (pll_edge) begin
      acc_r <= (acc_sum - per_r >= per_r) ? '0 : acc_sum - per_r;
    end else begin
      acc_r <= acc_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock after settling
  logic [31:0] settle_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_r <= '0;
      pll_lock <= 1'b0;
    end else if (cfg_wr) begin
      settle_r <= '0;
      pll_lock <= 1'b0;
    end else if (settle_r + 32'(1) >= 32'(SETTLE_CYCLES)) begin
      pll_lock <= 1'b1;
    end else begin
      settle_r <= settle_r + 32'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock source switch
  pcc_pkg::pcc_sw_e sw_r;
  logic cur_src_r;
  logic want_src;
  logic old_edge;
  logic new_edge;
  logic sys_edge;
  logic lock_prev_r;

  assign want_src = src_r[pcc_pkg::SRC_BIT];
  assign old_edge = cur_src_r ? pll_edge : ext_edge;
  assign new_edge = cur_src_r ? ext_edge : pll_edge;
  assign sys_edge = (sw_r == pcc_pkg::SW_RUN) ? old_edge :
                    (sw_r == pcc_pkg::SW_WAIT_LOW) ? (old_edge && system_clock) :
                    new_edge;

  // park low, then resume on the new source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_r <= pcc_pkg::SW_RUN;
      cur_src_r <= 1'b0;
    end else begin
      case (sw_r)
        pcc_pkg::SW_RUN: begin
          if (want_src != cur_src_r) begin
            sw_r <= pcc_pkg::SW_WAIT_LOW;
          end
        end
        pcc_pkg::SW_WAIT_LOW: begin
          if (!system_clock || (old_edge && system_clock)) begin
            sw_r <= pcc_pkg::SW_WAIT_NEW;
          end
        end
        pcc_pkg::SW_WAIT_NEW: begin
          if (new_edge) begin
            cur_src_r <= ~cur_src_r;
            sw_r <= pcc_pkg::SW_RUN;
          end
        end
        default: sw_r <= pcc_pkg::SW_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock <= 1'b0;
    end else if (sys_edge) begin
      system_clock <= ~system_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel clock
  logic [pcc_pkg::PDIV_W-1:0] pdiv_code;
  logic [pcc_pkg::PDIV_W:0] pdiv_ratio;
  logic sys_edge_r;

  // Registered so the divider sees the same edge that toggled system_clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_edge_r <= 1'b0;
    end else begin
      sys_edge_r <= sys_edge;
    end
  end

  // reserved code behaves as the smallest ratio
  assign pdiv_code = src_r[pcc_pkg::PDIV_LSB +: pcc_pkg::PDIV_W];
  assign pdiv_ratio = (pdiv_code == '0) ? (pcc_pkg::PDIV_W+1)'(2) :
                      {1'b0, pdiv_code} + (pcc_pkg::PDIV_W+1)'(1);

  // equal system edges per half period
  pcc_edge_div #(.W(pcc_pkg::PDIV_W + 1)) u_pclk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .edge_in(sys_edge_r),
    .ratio(pdiv_ratio),
    .level_r(panel_clock),
    .edge_r()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_prev_r <= 1'b0;
    end else begin
      lock_prev_r <= pll_lock;
    end
  end

  assign irq_evt[pcc_pkg::IRQ_LOCK] = pll_lock && !lock_prev_r;
  assign irq_evt[pcc_pkg::IRQ_SWITCH] = (sw_r == pcc_pkg::SW_WAIT_NEW) && new_edge;

endmodule

`default_nettype wire

// File: tb/pcc_assertions.sv
// Purpose: Port-level checks of the clock configuration block
// Assumes: Synchronous active-low reset, one clock domain
// Notes: Bound to every pcc_top instance
`default_nettype none

module pcc_assertions #(
  parameter int SETTLE_CYCLES = 50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic system_clock,
  input wire logic panel_clock,
  input wire logic pll_lock
);
  int cnt_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Cycles that lock has been low; a rise must follow a full settle span
  always_ff @(posedge aclk) begin
    if (!aresetn || pll_lock) begin
      cnt_r <= 0;
    end else if (cnt_r < SETTLE_CYCLES) begin
      cnt_r <= cnt_r + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during answer");
  a_lock_settle: assert property (
    $rose(pll_lock) |-> cnt_r >= SETTLE_CYCLES) else $error("lock before settle time");
  a_panel_cause: assert property (
    !$stable(panel_clock) |-> ($past(system_clock, 1) != $past(system_clock, 2))
    || ($past(system_clock, 2) != $past(system_clock, 3))) else $error("panel edge without system edge");
endmodule

bind pcc_top pcc_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .system_clock(system_clock), .panel_clock(panel_clock), .pll_lock(pll_lock));

`default_nettype wire

// File: tb/pcc_tb_top.sv
// Purpose: Self-checking bench for the clock configuration block
// Assumes: Shortened settle time; external pin toggles every G cycles
// Notes: PLL edge counts allow one edge of rate-model jitter
`default_nettype none

module pcc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 50;
  localparam int G = 8;
  localparam logic [1:0] OK = pcc_pkg::RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ext = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sys, pan, lock, irq, sys_q, pan_q;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails = 0;
  int total_checks = 0;
  int sys_cnt, pan_cnt, hi_len, lo_len;
  int run = 0;

  pcc_top #(.SETTLE_CYCLES(ST)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_clock_input(ext), .system_clock(sys), .panel_clock(pan), .pll_lock(lock), .irq(irq));

  always #25 aclk = ~aclk;

  // Edge counts and panel half-period lengths in aclk cycles
  always @(posedge aclk) begin
    run++;
    if (sys !== sys_q) sys_cnt++;
    if (pan !== pan_q) begin
      pan_cnt++;
      if (pan_q) hi_len = run;
      else lo_len = run;
      run = 0;
    end
    sys_q = sys;
    pan_q = pan;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Response ready goes up with the request; only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic ext_run(input int n);
    repeat (n) begin
      ext <= ~ext;
      repeat (G) @(posedge aclk);
    end
  endtask

  task automatic clr;
    @(negedge aclk);
    sys_cnt = 0;
    pan_cnt = 0;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ra [9] = '{8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h84};
    foreach (ra[i]) rd(ra[i], 32'h0, OK);
    rd(8'hfc, 32'h0, pcc_pkg::RESP_SLVERR);
    wr(8'hfc, 32'hff, pcc_pkg::RESP_SLVERR);
  endtask

  task automatic t_setup;
    logic [7:0] sa [5] = '{8'h18, 8'h20, 8'h28, 8'h30, 8'h38};
    logic [7:0] sv [5] = '{8'hf8, 8'h80, 8'h28, 8'h00, 8'h05};
    foreach (sa[i]) wr(sa[i], {24'h0, sv[i]}, OK);
    wr(8'h40, 32'hff, OK);
    foreach (sa[i]) rd(sa[i], {24'h0, sv[i]}, OK);
    chk(lock, 1'b0);
    repeat (ST + 5) @(posedge aclk);
    chk(lock, 1'b1);
    rd(8'h10, 32'h80, OK);
    wr(8'h40, 32'hff, OK);
    chk(lock, 1'b1);
    rd(8'h40, 32'h0, OK);
    wstrb <= 4'h0;
    wr(8'h48, 32'hff, OK);
    wstrb <= 4'h1;
    rd(8'h48, 32'h0, OK);
    chk(irq, 1'b0);
    wr(8'h84, 32'h1, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    rd(8'h80, 32'h1, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
  endtask

  // Ascending ratios so a leftover old half period ends inside the warm-up
  task automatic t_panel;
    logic [4:0] codes [4] = '{5'h01, 5'h00, 5'h02, 5'h1f};
    int r;
    foreach (codes[i]) begin
      r = (codes[i] == 5'h00) ? 2 : int'(codes[i]) + 1;
      wr(8'h48, {24'h0, codes[i], 3'h0}, OK);
      ext_run(2 * r);
      clr();
      ext_run(4 * r);
      chk(sys_cnt, 4 * r);
      chk(pan_cnt, 4);
      chk(hi_len, r * G);
      chk(lo_len, r * G);
    end
  endtask

  task automatic t_pll;
    int e;
    wr(8'h38, 32'h1, OK);
    wr(8'h48, 32'h09, OK);
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, p, OK);
      ext_run(8);
      clr();
      ext_run(16);
      e = 32 / (p + 1);
      chk(sys_cnt >= e - 1 && sys_cnt <= e + 1, 1'b1);
    end
    rd(8'h80, 32'h3, OK);
    wr(8'h48, 32'h08, OK);
    ext_run(4);
    clr();
    ext_run(8);
    chk(sys_cnt, 8);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_setup();
    t_panel();
    t_pll();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
